// File: rtl/fifo_store.sv
// Flip-flop word storage with one write port and one read index.
// Assumes the caller never writes a slot that holds an unread word.
`timescale 1ns/10ps
module fifo_store #(
    parameter int DEPTH = 1024,
    parameter int WIDTH = 18
) (
    // Clock
    input wire logic i_core_clk,
    input wire logic i_clk_en,
    // Write port
    input wire logic i_wr,
    input wire logic [$clog2(DEPTH)-1:0] i_wr_index,
    input wire logic [WIDTH-1:0] i_wr_word,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] i_rd_index,
    output logic [WIDTH-1:0] o_rd_word
);

    logic [WIDTH-1:0] cells [DEPTH];

    // Contents are not reset; the cell at i_rd_index is presented whether written or not.
    always_ff @(posedge i_core_clk)
    begin
        if (i_clk_en && i_wr)
        begin
            cells[i_wr_index] <= i_wr_word;
        end
    end

    assign o_rd_word = cells[i_rd_index];

endmodule : fifo_store

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a group of pins.
// Assumes the pins are asynchronous to i_core_clk.
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Pins and synchronised copy
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_synced
);

    logic [WIDTH-1:0] first_stage;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            first_stage <= '0;
            o_synced <= '0;
        end
        else if (i_clk_en)
        begin
            first_stage <= i_pins;
            o_synced <= first_stage;
        end
    end

endmodule : pin_sync

// File: rtl/strobed_fifo_1024x18.sv
// Strobed first-in first-out buffer with level flags and offset define.
// Assumes all strobes and pins are asynchronous to i_core_clk and
// that each strobe level lasts at least three core clock periods.
//
// Operation
// R1: A rising load strobe stores the input word unless the buffer is full.
// R2: A rising unload strobe advances to the next word unless empty.
// R3: The buffer is full when loads exceed unloads by 1024.
// R4: Loads when full and unloads when empty change nothing.
// R5: Device reset low clears pointers, full and near high, half and empty low.
// R6: Reset leaves the output word at no particular value.
// R7: The outside logic resets the buffer after power-up before use.
// R8: Output words are not inverted and float while output enable is low.
// R9: The first load into an empty buffer raises empty and shows the word.
// R10: Later words appear only after a rising unload strobe.
// R11: Half flag is high at 512 or more words, low below.
// R12: Near flag is high at X or fewer, or 1024 minus X or more words.
// R13: A falling define strobe captures the data inputs as offset X.
// R14: Outside logic drops define, resets, then releases reset with define low.
// R15: Define held high through a reset cycle gives offset 256.
// R16: Every reset cycle sets the offset afresh, custom or default.
// R17: Load and unload strobes may be unrelated or coincident.
// R18: Input and output ports are separate and 18 bits each.
// R19: The offset comes from the nine lowest data input bits.
// R20: Strobe-side signals cross safely before occupancy and flags use them.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module strobed_fifo_1024x18
    import strobed_fifo_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int WIDTH = WORD_WIDTH
) (
    // Clock, reset and enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Strobe-side pins
    input wire logic i_load_strobe,
    input wire logic i_unload_strobe,
    input wire logic i_fifo_reset_n,
    input wire logic i_offset_define_strobe_n,
    input wire logic i_output_enable,
    input wire logic [WIDTH-1:0] i_write_word_in,
    // Data out and flags
    output logic [WIDTH-1:0] o_read_word_out,
    output logic o_read_word_drive_n,
    output logic o_full_n,
    output logic o_empty_n,
    output logic o_half_level_flag,
    output logic o_near_limit_flag,
    // Avalon-MM slave
    input wire logic [REG_ADDR_WIDTH-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_COUNT = CW'(HALF_LEVEL);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if ((1 << PW) != DEPTH || DEPTH < 4)
    begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 4");
    end
    if (OFFSET_WIDTH > PW || WIDTH < OFFSET_WIDTH || HALF_LEVEL > DEPTH)
    begin : g_bad_width
        $error("WIDTH or DEPTH too small for the offset field");
    end

    // ------------------------------------------------------------
    // Flag arithmetic
    // ------------------------------------------------------------
    function automatic logic near_limit(input logic [CW-1:0] cnt,
                                        input logic [OFFSET_WIDTH-1:0] x);
        logic [CW-1:0] xw;
        xw = CW'(x);
        near_limit = (cnt <= xw) || (cnt >= FULL_COUNT - xw); // R12
    endfunction : near_limit

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] ctrl_s;
    logic [WIDTH-1:0] data_s;

    pin_sync #(.WIDTH(5)) u_ctrl_sync ( // R20
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_pins({i_output_enable, i_offset_define_strobe_n,
                 i_fifo_reset_n, i_unload_strobe, i_load_strobe}),
        .o_synced(ctrl_s)
    );

    pin_sync #(.WIDTH(WIDTH)) u_data_sync ( // R20
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_pins(i_write_word_in),
        .o_synced(data_s)
    );

    wire load_s = ctrl_s[0];
    wire unload_s = ctrl_s[1];
    wire reset_n_s = ctrl_s[2];
    wire define_n_s = ctrl_s[3];
    wire oe_s = ctrl_s[4];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic load_d;
    logic unload_d;
    logic reset_n_d;
    logic define_n_d;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            load_d <= 1'b0;
            unload_d <= 1'b0;
            reset_n_d <= 1'b0;
            define_n_d <= 1'b0;
        end
        else if (i_clk_en)
        begin
            load_d <= load_s;
            unload_d <= unload_s;
            reset_n_d <= reset_n_s;
            define_n_d <= define_n_s;
        end
    end

    wire load_edge = load_s & ~load_d;
    wire unload_edge = unload_s & ~unload_d;
    wire reset_release = reset_n_s & ~reset_n_d;
    wire define_fall = ~define_n_s & define_n_d;

    // ------------------------------------------------------------
    // Occupancy and pointers
    // ------------------------------------------------------------
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic flush;
    logic [WIDTH-1:0] head_word;

    wire dev_hold = ~reset_n_s | flush; // R5
    wire do_load = load_edge & ~dev_hold & (count != FULL_COUNT); // R1 R3 R4
    wire do_unload = unload_edge & ~dev_hold & (count != '0); // R2 R4

    // Both strobes may land in one cycle; the count then stays put unless the buffer is full or empty.
    always_comb
    begin
        unique case ({do_load, do_unload}) // R17
            2'b10: next_count = count + 1'b1;
            2'b01: next_count = count - 1'b1;
            default: next_count = count;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end
        else if (i_clk_en)
        begin
            if (dev_hold)
            begin
                wptr <= '0; // R5
                rptr <= '0;
                count <= '0;
            end
            else
            begin
                wptr <= wptr + PW'(do_load); // R1
                rptr <= rptr + PW'(do_unload); // R2 R10
                count <= next_count;
            end
        end
    end

    fifo_store #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_store (
        .i_core_clk(i_core_clk),
        .i_clk_en(i_clk_en),
        .i_wr(do_load),
        .i_wr_index(wptr),
        .i_wr_word(data_s),
        .i_rd_index(rptr),
        .o_rd_word(head_word)
    );

    // ------------------------------------------------------------
    // Almost offset
    // ------------------------------------------------------------
    logic [OFFSET_WIDTH-1:0] offset_x;
    logic [OFFSET_WIDTH-1:0] custom_x;
    logic custom_armed;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            offset_x <= DEFAULT_OFFSET;
            custom_x <= '0;
            custom_armed <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (define_fall)
            begin
                custom_x <= data_s[OFFSET_WIDTH-1:0]; // R13 R19
                custom_armed <= 1'b1;
            end
            else if (define_n_s || reset_release)
            begin
                custom_armed <= 1'b0;
            end
            if (reset_release)
            begin
                offset_x <= (custom_armed && !define_n_s) ? custom_x
                                                          : DEFAULT_OFFSET; // R15 R16
            end
        end
    end

    // ------------------------------------------------------------
    // Flags and output word
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_full_n <= 1'b1;
            o_empty_n <= 1'b0;
            o_half_level_flag <= 1'b0;
            o_near_limit_flag <= 1'b1;
            o_read_word_out <= '0;
            o_read_word_drive_n <= 1'b1;
        end
        else if (i_clk_en)
        begin
            o_read_word_drive_n <= ~oe_s; // R8
            if (dev_hold)
            begin
                o_full_n <= 1'b1; // R5
                o_empty_n <= 1'b0;
                o_half_level_flag <= 1'b0;
                o_near_limit_flag <= 1'b1;
            end
            else
            begin
                o_full_n <= (count != FULL_COUNT); // R3
                o_empty_n <= (count != '0); // R9
                o_half_level_flag <= (count >= HALF_COUNT); // R11
                o_near_limit_flag <= near_limit(count, offset_x); // R12
            end
            // The head word falls through without an unload strobe; a
            // buffer just reset keeps whatever word it last showed.
            if (count != '0)
            begin
                o_read_word_out <= head_word; // R6 R9 R10 R18
            end
        end
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    wire [31:0] status_word = 32'(count) << STATUS_COUNT_LSB
                            | 32'(o_empty_n) << STATUS_EMPTY_N_BIT
                            | 32'(o_full_n) << STATUS_FULL_N_BIT
                            | 32'(o_half_level_flag) << STATUS_HALF_BIT
                            | 32'(o_near_limit_flag) << STATUS_NEAR_BIT
                            | 32'(dev_hold) << STATUS_IN_RESET_BIT;
    wire [31:0] read_mux = (i_avs_address == REG_STATUS) ? status_word
                         : (i_avs_address == REG_OFFSET) ? 32'(offset_x)
                         : 32'h0;
    wire bus_req = i_avs_read | i_avs_write;
    wire wr_done = i_avs_write & ~o_avs_waitrequest;
    wire flush_hit = wr_done & (i_avs_address == REG_CONTROL)
                   & i_avs_writedata[CONTROL_FLUSH_BIT];

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0;
            flush <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
            flush <= flush_hit;
            if (i_avs_read && o_avs_waitrequest)
            begin
                o_avs_readdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_first_load;
        i_clk_en && count == '0 && do_load ##1 i_clk_en && !dev_hold;
    endsequence

    sequence s_release_default;
        i_clk_en && reset_release && define_n_s;
    endsequence

    load_store_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R1
        i_clk_en && load_edge && !dev_hold && count < FULL_COUNT
        |=> wptr == $past(wptr) + 1'b1)
        else $error("load edge did not store a word");

    unload_step_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R2
        i_clk_en && unload_edge && !dev_hold && count != '0
        |=> rptr == $past(rptr) + 1'b1)
        else $error("unload edge did not advance");

    count_cap_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R3
        count <= FULL_COUNT && (o_full_n || count == FULL_COUNT || $past(dev_hold)
                                || $past(count) == FULL_COUNT))
        else $error("occupancy beyond depth or full flag wrong");

    full_block_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R4
        i_clk_en && load_edge && count == FULL_COUNT && !unload_edge && !dev_hold
        |=> $stable(wptr) && count == FULL_COUNT)
        else $error("load changed a full buffer");

    reset_flags_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R5
        i_clk_en && dev_hold |=> count == '0 && o_full_n && o_near_limit_flag
        && !o_half_level_flag && !o_empty_n)
        else $error("device reset did not force flags");

    drive_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R8
        i_clk_en |=> o_read_word_drive_n == !$past(oe_s))
        else $error("output enable not followed");

    fall_through_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R9
        s_first_load |=> o_empty_n && o_read_word_out == $past(data_s, 2))
        else $error("first word did not fall through");

    half_level_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R11
        i_clk_en && !dev_hold |=> o_half_level_flag == ($past(count) >= HALF_COUNT))
        else $error("half flag wrong");

    near_limit_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R12
        i_clk_en && !dev_hold
        |=> o_near_limit_flag == near_limit($past(count), $past(offset_x)))
        else $error("near flag wrong");

    default_offset_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // R15
        s_release_default |=> offset_x == DEFAULT_OFFSET)
        else $error("default offset not applied");

endmodule : strobed_fifo_1024x18

// File: shared/strobed_fifo_pkg.sv
// Constants shared by the strobed FIFO design files.
// Assumes a 32-bit register bus addressed by word index.
package strobed_fifo_pkg;

    // ------------------------------------------------------------
    // Storage shape
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 1024;
    localparam int WORD_WIDTH = 18;
    localparam int HALF_LEVEL = 512;
    localparam int OFFSET_WIDTH = 9;
    localparam logic [8:0] DEFAULT_OFFSET = 9'h100;

    // ------------------------------------------------------------
    // Register map, word index on the bus
    // ------------------------------------------------------------
    localparam int REG_ADDR_WIDTH = 2;
    localparam logic [1:0] REG_STATUS = 2'h0;
    localparam logic [1:0] REG_OFFSET = 2'h1;
    localparam logic [1:0] REG_CONTROL = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_EMPTY_N_BIT = 16;
    localparam int STATUS_FULL_N_BIT = 17;
    localparam int STATUS_HALF_BIT = 18;
    localparam int STATUS_NEAR_BIT = 19;
    localparam int STATUS_IN_RESET_BIT = 20;
    localparam int CONTROL_FLUSH_BIT = 0;

endpackage : strobed_fifo_pkg

// File: verification/strobe_partner.sv
// Far-side system logic that loads and unloads words by strobes.
// Assumes each call runs alone; strobes stand still between calls.
`timescale 1ns/10ps
module strobe_partner
    import strobed_fifo_pkg::*;
(
    // Strobes and device reset
    output logic o_load_strobe,
    output logic o_unload_strobe,
    output logic o_fifo_reset_n,
    output logic o_offset_define_strobe_n,
    // Data toward the buffer
    output logic [WORD_WIDTH-1:0] o_word
);
    initial
    begin
        o_load_strobe = 1'b0;
        o_unload_strobe = 1'b0;
        o_fifo_reset_n = 1'b1;
        o_offset_define_strobe_n = 1'b1;
        o_word = '0;
    end

    // One 48 ns link cycle; the word is inverted once it is no longer valid.
    task automatic move(input logic ld, input logic ul, input logic [WORD_WIDTH-1:0] w);
        o_word <= w;
        #12.7;
        o_load_strobe <= ld;
        o_unload_strobe <= ul;
        #24;
        o_load_strobe <= 1'b0;
        o_unload_strobe <= 1'b0;
        o_word <= ~w;
        #11.3;
    endtask : move

    // Pulse reset; with custom set, define drops first and is still low at the release.
    task automatic device_reset(input logic custom, input logic [WORD_WIDTH-1:0] w);
        if (custom)
        begin
            o_word <= w;
            #12.7;
            o_offset_define_strobe_n <= 1'b0;
            #12;
        end
        o_fifo_reset_n <= 1'b0;
        #40;
        o_fifo_reset_n <= 1'b1;
        #24;
        o_offset_define_strobe_n <= 1'b1;
        o_word <= ~w;
        #43.3;
    endtask : device_reset
endmodule : strobe_partner

// File: verification/strobed_fifo_1024x18_bench.sv
// Self-checking bench for the strobed buffer and its register bus.
// Assumes the partner model drives all strobe-side pins except output enable, which the bench drives.
`timescale 1ns/10ps
module strobed_fifo_1024x18_bench
    import strobed_fifo_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic clk_en = 1'b1;
    logic oe = 1'b1;
    logic [1:0] address = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic waitreq;
    logic ld, ul, frst_n, def_n, drive_n, full_n, empty_n, half, near;
    logic [WORD_WIDTH-1:0] win, wout;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] d;

    strobe_partner u_far (
        .o_load_strobe(ld), .o_unload_strobe(ul), .o_fifo_reset_n(frst_n),
        .o_offset_define_strobe_n(def_n), .o_word(win)
    );

    strobed_fifo_1024x18 u_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(clk_en),
        .i_load_strobe(ld), .i_unload_strobe(ul), .i_fifo_reset_n(frst_n),
        .i_offset_define_strobe_n(def_n), .i_output_enable(oe), .i_write_word_in(win),
        .o_read_word_out(wout), .o_read_word_drive_n(drive_n), .o_full_n(full_n),
        .o_empty_n(empty_n), .o_half_level_flag(half), .o_near_limit_flag(near),
        .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq)
    );

    initial
    begin
        forever #2 i_core_clk = ~i_core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic flags(input int n, input int x);
        check(full_n, n < FIFO_DEPTH, "full flag");
        check(empty_n, n > 0, "empty flag");
        check(half, n >= HALF_LEVEL, "half flag");
        check(near, n <= x || n >= FIFO_DEPTH - x, "near flag");
    endtask : flags

    task automatic bus_read(input logic [1:0] a, output logic [31:0] q);
        @(posedge i_core_clk);
        address <= a;
        rd <= 1'b1;
        do @(posedge i_core_clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
    endtask : bus_read

    task automatic bus_write(input logic [1:0] a, input logic [31:0] v);
        @(posedge i_core_clk);
        address <= a;
        wdata <= v;
        wr <= 1'b1;
        do @(posedge i_core_clk); while (waitreq !== 1'b0);
        wr <= 1'b0;
    endtask : bus_write

    function automatic logic [WORD_WIDTH-1:0] pat(input int i);
        return WORD_WIDTH'(i * 37) ^ 18'h2a5a5;
    endfunction : pat

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    always @(posedge i_core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_fail++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        u_far.device_reset(1'b0, '0);
        flags(0, 256);
        bus_read(REG_OFFSET, d);
        check(d, 32'(DEFAULT_OFFSET), "default offset");
        $display("Test reset done");

        u_far.move(1'b1, 1'b0, pat(1));
        check(wout, pat(1), "fall through");
        check(drive_n, 1'b0, "driving");
        u_far.move(1'b1, 1'b0, pat(2));
        check(wout, pat(1), "head held");
        u_far.move(1'b1, 1'b1, pat(3));
        check(wout, pat(2), "coincident");
        u_far.move(1'b0, 1'b1, '0);
        check(wout, pat(3), "unload");
        u_far.move(1'b0, 1'b1, '0);
        flags(0, 256);
        u_far.move(1'b0, 1'b1, '0);
        flags(0, 256);
        u_far.move(1'b1, 1'b0, pat(4));
        check(wout, pat(4), "load after empty");
        oe <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        check(drive_n, 1'b1, "released");
        oe <= 1'b1;
        u_far.device_reset(1'b0, '0);
        flags(0, 256);
        $display("Test fall through done");

        for (int i = 1; i <= FIFO_DEPTH; i++)
        begin
            u_far.move(1'b1, 1'b0, pat(i));
            flags(i, 256);
        end
        u_far.move(1'b1, 1'b0, pat(0));
        flags(FIFO_DEPTH, 256);
        bus_read(REG_STATUS, d);
        check(d[10:0], 11'h400, "count");
        check(d[19:16], 4'hd, "status flags");
        for (int i = 1; i <= FIFO_DEPTH; i++)
        begin
            check(wout, pat(i), "drain order");
            u_far.move(1'b0, 1'b1, '0);
            flags(FIFO_DEPTH - i, 256);
        end
        $display("Test fill and drain done");

        u_far.device_reset(1'b1, 18'h3fe05);
        bus_read(REG_OFFSET, d);
        check(d, 32'h5, "custom offset");
        for (int i = 1; i <= 7; i++)
        begin
            u_far.move(1'b1, 1'b0, pat(i));
            flags(i, 5);
        end
        u_far.device_reset(1'b0, '0);
        flags(0, 256);
        bus_read(REG_OFFSET, d);
        check(d, 32'(DEFAULT_OFFSET), "offset renewed");
        $display("Test offset done");

        bus_read(2'h3, d);
        check(d, 32'h0, "unmapped");
        bus_write(REG_OFFSET, 32'h9);
        bus_read(REG_OFFSET, d);
        check(d, 32'(DEFAULT_OFFSET), "offset read only");
        u_far.move(1'b1, 1'b0, pat(8));
        u_far.move(1'b1, 1'b0, pat(9));
        bus_write(REG_CONTROL, 32'h1);
        repeat (4) @(posedge i_core_clk);
        flags(0, 256);
        $display("Test registers done");
        test_done();
    end
endmodule : strobed_fifo_1024x18_bench
